//--- verilog/rsc_state_ctrl.sv
// Radio enable state machine: pin and register control of standby, receive,
// transmit and full-duplex states, chain enables, VCO calibration requests
// and sleep. Assumes the register port is the core_clk side of a serial
// register slave, flush_tick is a one-cycle pulse per ADC clock / 64.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"

module rsc_state_ctrl (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // Control pins
    input  wire logic        enable_pin,
    input  wire logic        tx_rx_select_pin,
    input  wire logic        flush_tick,
    input  wire logic        baseband_pll_locked,
    // Register port
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [9:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    // Transmit data path
    input  wire logic        tx_frame,
    input  wire logic [11:0] tx_data_in,
    output logic      [11:0] tx_data_out,
    // Radio controls
    output logic             rx_chain_en,
    output logic             tx_chain_en,
    output logic             rx_synth_en,
    output logic             tx_synth_en,
    output logic             rx_cal_req,
    output logic             tx_cal_req,
    output logic      [3:0]  state_code,
    output logic      [7:0]  clock_enable_control
);

    localparam logic [7:0] LOAD_CYC = 8'(`RSC_LOAD_DELAY_CYC);
    localparam logic [2:0] FLUSH_N  = 3'(`RSC_FLUSH_TICKS);

    typedef struct packed {
        rsc_pkg::rsc_state_e state;
        logic [7:0]          dly_cnt;
        logic [2:0]          flush_cnt;
        logic [7:0]          cal_cnt;
        logic                cal_pend;
        logic [7:0]          clk_ctrl;
        logic [7:0]          cfg1;
        logic [7:0]          cfg2;
        logic [7:0]          rx_cal_ctl;
        logic [7:0]          tx_cal_ctl;
        logic                spi_cmd;
        logic                rx_chain;
        logic                tx_chain;
        logic                rx_synth;
        logic                tx_synth;
        logic                rx_cal;
        logic                tx_cal;
        logic [3:0]          code;
        logic [7:0]          rdata;
        logic                rvalid;
        logic [11:0]         txd;
    } rsc_ctrl_s;

    rsc_ctrl_s r_q;
    rsc_ctrl_s r_d;

    logic [1:0] pin_async;
    logic [1:0] pin_lvl;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    assign pin_async = {tx_rx_select_pin, enable_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pin
            rsc_sync_edge u_sync (
                .core_clk (core_clk),
                .sys_rst  (sys_rst),
                .pin_in   (pin_async[gi]),
                .level    (pin_lvl[gi]),
                .rise     (pin_rise[gi]),
                .fall     (pin_fall[gi])
            );
        end
    endgenerate

    logic en_lvl;
    logic en_rise;
    logic en_fall;
    logic sel_lvl;
    logic sel_rise;
    logic sel_fall;

    assign en_lvl   = pin_lvl[0];
    assign en_rise  = pin_rise[0];
    assign en_fall  = pin_fall[0];
    assign sel_lvl  = pin_lvl[1];
    assign sel_rise = pin_rise[1];
    assign sel_fall = pin_fall[1];

    always_comb
    begin
        logic awake;
        logic fdd;
        logic indep;
        logic level_md;
        logic to_stby;
        logic f_rx;
        logic f_tx;
        logic en_exit;
        logic cal_rx_ok;
        logic cal_tx_ok;
        logic int_wr;
        logic cal_rx;
        logic cal_tx;
        rsc_pkg::rsc_state_e leave_to;

        awake     = (r_q.clk_ctrl != 8'h00);
        fdd       = r_q.cfg2[`RSC_CFG2_FULL_DUPLEX];
        indep     = fdd & r_q.cfg2[`RSC_CFG2_INDEP];
        level_md  = r_q.cfg1[`RSC_CFG1_LEVEL_MODE];
        to_stby   = r_q.cfg1[`RSC_CFG1_TO_STANDBY];
        f_rx      = r_q.cfg1[`RSC_CFG1_FORCE_RX];
        f_tx      = r_q.cfg1[`RSC_CFG1_FORCE_TX];
        en_exit   = level_md ? en_fall : en_rise;
        cal_rx_ok = ~r_q.rx_cal_ctl[`RSC_CAL_DISABLE];
        cal_tx_ok = ~r_q.tx_cal_ctl[`RSC_CAL_DISABLE];
        int_wr    = reg_wr & ((reg_addr == `RSC_ADDR_RX_INT_WORD)
                              | (reg_addr == `RSC_ADDR_TX_INT_WORD));
        cal_rx    = 1'b0;
        cal_tx    = 1'b0;
        leave_to  = to_stby ? rsc_pkg::ST_STANDBY : rsc_pkg::ST_WAIT;

        r_d         = r_q;
        r_d.spi_cmd = 1'b0;
        r_d.rvalid  = reg_rd;

        // Register writes take effect on the next edge.
        if (reg_wr)
        begin
            unique case (reg_addr)
                `RSC_ADDR_CLK_CTRL:   r_d.clk_ctrl   = reg_wdata;
                `RSC_ADDR_CFG1:
                begin
                    r_d.cfg1    = reg_wdata;
                    r_d.spi_cmd = 1'b1;
                end
                `RSC_ADDR_CFG2:       r_d.cfg2       = reg_wdata;
                `RSC_ADDR_RX_CAL_CTL: r_d.rx_cal_ctl = reg_wdata;
                `RSC_ADDR_TX_CAL_CTL: r_d.tx_cal_ctl = reg_wdata;
                default:              r_d.clk_ctrl   = r_q.clk_ctrl;
            endcase
        end

        if (reg_rd)
        begin
            unique case (reg_addr)
                `RSC_ADDR_CLK_CTRL:   r_d.rdata = r_q.clk_ctrl;
                `RSC_ADDR_CFG1:       r_d.rdata = r_q.cfg1;
                `RSC_ADDR_CFG2:       r_d.rdata = r_q.cfg2;
                `RSC_ADDR_PLL_LOCK:   r_d.rdata = {baseband_pll_locked, 7'h00};
                `RSC_ADDR_RX_CAL_CTL: r_d.rdata = r_q.rx_cal_ctl;
                `RSC_ADDR_TX_CAL_CTL: r_d.rdata = r_q.tx_cal_ctl;
                default:              r_d.rdata = 8'h00;
            endcase
        end

        if (awake)
        begin
            unique case (r_q.state)
                rsc_pkg::ST_WAIT:
                begin
                    if (en_rise | (r_q.spi_cmd & r_q.cfg1[`RSC_CFG1_FORCE_STBY]))
                    begin
                        r_d.state   = rsc_pkg::ST_DELAY;
                        r_d.dly_cnt = LOAD_CYC;
                    end
                end
                rsc_pkg::ST_DELAY:
                begin
                    if (r_q.dly_cnt <= 8'h01)
                    begin
                        r_d.state = rsc_pkg::ST_STANDBY;
                        cal_rx    = fdd | ~sel_lvl;
                        cal_tx    = fdd | sel_lvl;
                    end
                    else
                    begin
                        r_d.dly_cnt = r_q.dly_cnt - 8'h01;
                    end
                end
                rsc_pkg::ST_STANDBY:
                begin
                    if (r_q.spi_cmd & f_tx)
                    begin
                        r_d.state = fdd ? rsc_pkg::ST_FDD : rsc_pkg::ST_TX;
                        r_d.rx_chain = 1'b0;
                        r_d.tx_chain = 1'b0;
                    end
                    else if (r_q.spi_cmd & f_rx & ~fdd)
                    begin
                        r_d.state = rsc_pkg::ST_RX;
                    end
                    else if (en_rise & ~indep)
                    begin
                        if (fdd)
                            r_d.state = rsc_pkg::ST_FDD;
                        else if (sel_lvl)
                            r_d.state = rsc_pkg::ST_TX;
                        else
                            r_d.state = rsc_pkg::ST_RX;
                    end
                end
                rsc_pkg::ST_TX,
                rsc_pkg::ST_RX:
                begin
                    if (en_exit | (r_q.spi_cmd & ~f_tx & ~f_rx))
                    begin
                        r_d.state     = (r_q.state == rsc_pkg::ST_TX)
                                        ? rsc_pkg::ST_TX_FLUSH : rsc_pkg::ST_RX_FLUSH;
                        r_d.flush_cnt = FLUSH_N;
                    end
                end
                rsc_pkg::ST_FDD:
                begin
                    if (indep)
                    begin
                        if (r_q.spi_cmd & ~f_tx)
                            r_d.state = leave_to;
                    end
                    else if (en_exit | (r_q.spi_cmd & ~f_tx))
                    begin
                        r_d.state     = rsc_pkg::ST_FDD_FLUSH;
                        r_d.flush_cnt = FLUSH_N;
                    end
                end
                rsc_pkg::ST_TX_FLUSH,
                rsc_pkg::ST_RX_FLUSH,
                rsc_pkg::ST_FDD_FLUSH:
                begin
                    if (flush_tick)
                    begin
                        r_d.flush_cnt = r_q.flush_cnt - 3'h1;
                        if (r_q.flush_cnt == 3'h1)
                            r_d.state = leave_to;
                    end
                end
                default:
                    r_d.state = rsc_pkg::ST_WAIT;
            endcase
        end

        if (indep & (r_q.state == rsc_pkg::ST_FDD) & (r_d.state == rsc_pkg::ST_FDD))
        begin
            if (level_md)
            begin
                r_d.rx_chain = en_lvl;
                r_d.tx_chain = sel_lvl;
            end
            else
            begin
                r_d.rx_chain = r_q.rx_chain ^ en_rise;
                r_d.tx_chain = r_q.tx_chain ^ sel_rise;
            end
        end
        else if (r_d.state != rsc_pkg::ST_FDD)
        begin
            r_d.rx_chain = (r_d.state == rsc_pkg::ST_RX);
            r_d.tx_chain = (r_d.state == rsc_pkg::ST_TX);
        end
        else
        begin
            r_d.rx_chain = ~indep;
            r_d.tx_chain = ~indep;
        end

        unique case (r_d.state)
            rsc_pkg::ST_WAIT,
            rsc_pkg::ST_DELAY:
            begin
                r_d.rx_synth = 1'b0;
                r_d.tx_synth = 1'b0;
            end
            rsc_pkg::ST_RX,
            rsc_pkg::ST_RX_FLUSH:
            begin
                r_d.rx_synth = 1'b1;
                r_d.tx_synth = fdd;
            end
            rsc_pkg::ST_TX,
            rsc_pkg::ST_TX_FLUSH:
            begin
                r_d.rx_synth = fdd;
                r_d.tx_synth = 1'b1;
            end
            rsc_pkg::ST_STANDBY:
            begin
                r_d.rx_synth = fdd | ~sel_lvl;
                r_d.tx_synth = fdd | sel_lvl;
            end
            default:
            begin
                r_d.rx_synth = 1'b1;
                r_d.tx_synth = 1'b1;
            end
        endcase

        // integer word write in full duplex or time division
        if (awake & int_wr)
        begin
            if (fdd)
            begin
                cal_rx = 1'b1;
                cal_tx = 1'b1;
            end
            else if ((r_q.state == rsc_pkg::ST_STANDBY) | (r_q.state == rsc_pkg::ST_RX)
                     | (r_q.state == rsc_pkg::ST_TX))
            begin
                cal_rx = cal_rx | ~sel_lvl;
                cal_tx = cal_tx | sel_lvl;
            end
        end

        if (awake & ~fdd & (sel_rise | sel_fall))
        begin
            r_d.cal_pend = 1'b1;
            r_d.cal_cnt  = LOAD_CYC;
        end
        else if (r_q.cal_pend)
        begin
            if (r_q.cal_cnt <= 8'h01)
            begin
                r_d.cal_pend = 1'b0;
                cal_rx       = cal_rx | ~sel_lvl;
                cal_tx       = cal_tx | sel_lvl;
            end
            else
            begin
                r_d.cal_cnt = r_q.cal_cnt - 8'h01;
            end
        end

        r_d.rx_cal = cal_rx & cal_rx_ok;
        r_d.tx_cal = cal_tx & cal_tx_ok;

        r_d.txd = tx_frame ? tx_data_in : 12'h000;

        unique case (r_d.state)
            rsc_pkg::ST_WAIT:      r_d.code = 4'h0;
            rsc_pkg::ST_DELAY:     r_d.code = 4'h4;
            rsc_pkg::ST_STANDBY:   r_d.code = 4'h5;
            rsc_pkg::ST_TX:        r_d.code = 4'h6;
            rsc_pkg::ST_TX_FLUSH:  r_d.code = 4'h7;
            rsc_pkg::ST_RX:        r_d.code = 4'h8;
            rsc_pkg::ST_RX_FLUSH:  r_d.code = 4'h9;
            rsc_pkg::ST_FDD:       r_d.code = 4'ha;
            rsc_pkg::ST_FDD_FLUSH: r_d.code = 4'hb;
            default:               r_d.code = 4'h0;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_q            <= '0;
            r_q.state      <= rsc_pkg::ST_WAIT;
            r_q.clk_ctrl   <= `RSC_CLK_CTRL_RST;
            r_q.cfg1       <= `RSC_CFG1_RST;
            r_q.cfg2       <= `RSC_CFG2_RST;
            r_q.rx_cal_ctl <= `RSC_CAL_CTL_RST;
            r_q.tx_cal_ctl <= `RSC_CAL_CTL_RST;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign reg_rdata            = r_q.rdata;
    assign reg_rvalid           = r_q.rvalid;
    assign tx_data_out          = r_q.txd;
    assign rx_chain_en          = r_q.rx_chain;
    assign tx_chain_en          = r_q.tx_chain;
    assign rx_synth_en          = r_q.rx_synth;
    assign tx_synth_en          = r_q.tx_synth;
    assign rx_cal_req           = r_q.rx_cal;
    assign tx_cal_req           = r_q.tx_cal;
    assign state_code           = r_q.code;
    assign clock_enable_control = r_q.clk_ctrl;

endmodule : rsc_state_ctrl

`default_nettype wire

//--- verilog/rsc_defs.svh
// Register offsets, field positions, reset values and timing counts for the
// radio state control block. Assumes a 20 MHz core clock.
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// Register offsets (10-bit register address space).
`define RSC_ADDR_CLK_CTRL    10'h009
`define RSC_ADDR_CFG1        10'h014
`define RSC_ADDR_CFG2        10'h015
`define RSC_ADDR_PLL_LOCK    10'h05e
`define RSC_ADDR_RX_CAL_CTL  10'h230
`define RSC_ADDR_RX_INT_WORD 10'h231
`define RSC_ADDR_TX_CAL_CTL  10'h270
`define RSC_ADDR_TX_INT_WORD 10'h271

// Field positions.
`define RSC_CFG1_TO_STANDBY  0
`define RSC_CFG1_FORCE_STBY  2
`define RSC_CFG1_LEVEL_MODE  3
`define RSC_CFG1_FORCE_TX    5
`define RSC_CFG1_FORCE_RX    6
`define RSC_CFG2_FULL_DUPLEX 3
`define RSC_CFG2_INDEP       7
`define RSC_CAL_DISABLE      0
`define RSC_PLL_LOCK_BIT     7

// Reset values.
`define RSC_CLK_CTRL_RST     8'h00
`define RSC_CFG1_RST         8'h08
`define RSC_CFG2_RST         8'h00
`define RSC_CAL_CTL_RST      8'h00

// Timing.
`define RSC_CLK_PERIOD_NS    50
`define RSC_LOAD_DELAY_NS    2000
`define RSC_LOAD_DELAY_CYC   ((`RSC_LOAD_DELAY_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)
`define RSC_FLUSH_TICKS      6

`endif

//--- verilog/rsc_pkg.sv
// Types shared by the radio state control block.
// Assumes rsc_defs.svh supplies every numeric constant.
package rsc_pkg;

    typedef enum logic [3:0] {
        ST_WAIT,
        ST_DELAY,
        ST_STANDBY,
        ST_TX,
        ST_TX_FLUSH,
        ST_RX,
        ST_RX_FLUSH,
        ST_FDD,
        ST_FDD_FLUSH
    } rsc_state_e;

endpackage : rsc_pkg

//--- verilog/rsc_sync_edge.sv
// Two-flop synchroniser with registered level, rise and fall outputs.
// Assumes the input pin is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none

module rsc_sync_edge (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // Pin and outputs
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic lvl;
        logic rise;
        logic fall;
    } rsc_sync_s;

    rsc_sync_s r_q;
    rsc_sync_s r_d;

    always_comb
    begin
        r_d      = r_q;
        r_d.meta = pin_in;
        r_d.sync = r_q.meta;
        r_d.lvl  = r_q.sync;
        r_d.rise = r_q.sync & ~r_q.lvl;
        r_d.fall = ~r_q.sync & r_q.lvl;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign level = r_q.lvl;
    assign rise  = r_q.rise;
    assign fall  = r_q.fall;

endmodule : rsc_sync_edge

`default_nettype wire

//--- bench/rsc_state_checker.sv
// Port assertions for the radio state control block.
// Assumes it is bound to rsc_state_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"

module rsc_state_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        sys_rst,
    // Inputs
    input wire logic        flush_tick,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [9:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        tx_frame,
    input wire logic [11:0] tx_data_in,
    // Outputs
    input wire logic [7:0]  reg_rdata,
    input wire logic [11:0] tx_data_out,
    input wire logic        rx_synth_en,
    input wire logic        tx_synth_en,
    input wire logic        rx_cal_req,
    input wire logic        tx_cal_req,
    input wire logic [3:0]  state_code,
    input wire logic [7:0]  clock_enable_control
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    logic [5:0] dly_q;
    logic [2:0] fl_q;
    logic       stby_q;
    logic       fdd_q;
    logic       ind_q;
    wire        in_fl = state_code inside {4'd7, 4'd9, 4'd11};

    // Write tracking lets the exit target be predicted without seeing inside.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            dly_q  <= 6'd0;
            fl_q   <= 3'd0;
            stby_q <= 1'b0;
            fdd_q  <= 1'b0;
            ind_q  <= 1'b0;
        end
        else
        begin
            dly_q <= (state_code == 4'd4) ? dly_q + 6'd1 : 6'd0;
            fl_q  <= in_fl ? fl_q + {2'd0, flush_tick} : 3'd0;
            if (reg_wr && reg_addr == `RSC_ADDR_CFG1)
                stby_q <= reg_wdata[0];
            if (reg_wr && reg_addr == `RSC_ADDR_CFG2)
                fdd_q <= reg_wdata[3];
            if (reg_wr && reg_addr == `RSC_ADDR_CFG2)
                ind_q <= reg_wdata[7];
        end
    end

    sequence cfg_wr;
        reg_wr && reg_addr == `RSC_ADDR_CFG2;
    endsequence
    sequence cfg_rd;
        reg_rd && reg_addr == `RSC_ADDR_CFG2;
    endsequence

    frame_zero_a: assert property (!tx_frame |=> tx_data_out == 12'h000)
        else $error("data not zeroed while frame low");
    frame_pass_a: assert property (tx_frame |=> tx_data_out == $past(tx_data_in))
        else $error("data not passed while frame high");
    delay_bound_a: assert property (state_code == 4'd4 |-> dly_q < `RSC_LOAD_DELAY_CYC)
        else $error("delay state too long");
    delay_exit_a: assert property ($past(state_code) == 4'd4 && state_code != 4'd4
        |-> state_code == 4'd5 && dly_q == `RSC_LOAD_DELAY_CYC)
        else $error("delay state wrong length or target");
    flush_len_a: assert property ($past(in_fl) && !in_fl |-> fl_q == 3'd6)
        else $error("flush not six ticks");
    flush_dest_a: assert property ($past(in_fl) && !in_fl
        |-> state_code == (stby_q ? 4'd5 : 4'd0))
        else $error("flush exit target wrong");
    wait_exit_a: assert property ($past(state_code) == 4'd0 && state_code != 4'd0
        |-> state_code == 4'd4)
        else $error("wait left to a state other than delay");
    sleep_hold_a: assert property (clock_enable_control == 8'h00 |=> $stable(state_code))
        else $error("state moved while asleep");
    cal_pulse_a: assert property (rx_cal_req || tx_cal_req |=> !rx_cal_req && !tx_cal_req)
        else $error("calibration request longer than one cycle");
    tdd_synth_a: assert property ($past(state_code) == 4'd8 && state_code == 4'd8
        && !fdd_q |-> !tx_synth_en && rx_synth_en)
        else $error("synthesizer power wrong in receive");
    indep_flush_a: assert property (ind_q |-> state_code != 4'd11)
        else $error("flush entered under independent control");
    cfg_back_a: assert property (cfg_wr ##1 cfg_rd |=> reg_rdata == $past(reg_wdata, 2))
        else $error("config readback wrong");
endmodule : rsc_state_checker

bind rsc_state_ctrl rsc_state_checker i_rsc_state_checker (
    .core_clk(core_clk), .sys_rst(sys_rst), .flush_tick(flush_tick), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .tx_frame(tx_frame),
    .tx_data_in(tx_data_in), .reg_rdata(reg_rdata), .tx_data_out(tx_data_out),
    .rx_synth_en(rx_synth_en), .tx_synth_en(tx_synth_en), .rx_cal_req(rx_cal_req),
    .tx_cal_req(tx_cal_req), .state_code(state_code),
    .clock_enable_control(clock_enable_control));
`default_nettype wire

//--- bench/rsc_bbp_model.sv
// Baseband side model: flush tick source and baseband PLL lock indication.
// Assumes pins and registers are driven by the bench; outputs move on falling edges.
`timescale 1ns/1ps
`default_nettype none

module rsc_bbp_model #(
    parameter int TICK_DIV = 5,
    parameter int LOCK_CYC = 20
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Device side
    input  wire logic [7:0] clock_enable_control,
    output logic            flush_tick,
    output logic            baseband_pll_locked
);
    int div_q;
    int lock_q;

    always @(negedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_q <= 0;
            lock_q <= 0;
            flush_tick <= 1'b0;
            baseband_pll_locked <= 1'b0;
        end
        else
        begin
            div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            flush_tick <= (div_q == TICK_DIV - 1);
            lock_q <= (clock_enable_control == 8'h00) ? 0 : lock_q + 1;
            baseband_pll_locked <= (lock_q >= LOCK_CYC);
        end
    end
endmodule : rsc_bbp_model
`default_nettype wire

//--- bench/rsc_state_ctrl_tb.sv
// Self-checking bench for the radio state control block.
// Assumes the checker is bound in and the baseband model supplies ticks and lock.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.svh"

module rsc_state_ctrl_tb;
    logic            core_clk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            enable_pin = 1'b0;
    logic            tx_rx_select_pin = 1'b0;
    logic            reg_wr = 1'b0;
    logic            reg_rd = 1'b0;
    logic [9:0]      reg_addr = 10'h000;
    logic [7:0]      reg_wdata = 8'h00;
    logic            tx_frame = 1'b0;
    logic [11:0]     tx_data_in = 12'h000;
    wire logic       flush_tick, baseband_pll_locked, reg_rvalid, rx_chain_en, tx_chain_en;
    wire logic       rx_synth_en, tx_synth_en, rx_cal_req, tx_cal_req;
    wire logic [7:0] reg_rdata, clock_enable_control;
    wire logic [11:0] tx_data_out;
    wire logic [3:0] state_code;
    int              n_fail = 0;
    int              compares = 0;
    int              cycles = 0;
    int              n_rxcal = 0;
    int              n_txcal = 0;

    rsc_state_ctrl i_rsc_state_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
        .enable_pin(enable_pin), .tx_rx_select_pin(tx_rx_select_pin),
        .flush_tick(flush_tick), .baseband_pll_locked(baseband_pll_locked),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .tx_frame(tx_frame),
        .tx_data_in(tx_data_in), .tx_data_out(tx_data_out), .rx_chain_en(rx_chain_en),
        .tx_chain_en(tx_chain_en), .rx_synth_en(rx_synth_en), .tx_synth_en(tx_synth_en),
        .rx_cal_req(rx_cal_req), .tx_cal_req(tx_cal_req), .state_code(state_code),
        .clock_enable_control(clock_enable_control));
    rsc_bbp_model i_rsc_bbp_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .clock_enable_control(clock_enable_control), .flush_tick(flush_tick),
        .baseband_pll_locked(baseband_pll_locked));

    always #25 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cycles++;
        n_rxcal += rx_cal_req;
        n_txcal += tx_cal_req;
        if (cycles == 5000)
        begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("fails %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic r, input logic [9:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
    endtask : bus

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask : wr

    task automatic rd(input logic [9:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        check(reg_rvalid, 1'b1);
    endtask : rd

    task automatic pins(input logic e, input logic s);
        @(negedge core_clk);
        enable_pin = e;
        tx_rx_select_pin = s;
    endtask : pins

    task automatic wait_state(input logic [3:0] code);
        int i;
        for (i = 0; i < 300 && state_code !== code; i++)
            @(negedge core_clk);
        check(state_code, code);
    endtask : wait_state

    task automatic s_reset();
        rd(`RSC_ADDR_CFG1);
        check(reg_rdata, `RSC_CFG1_RST);
        rd(`RSC_ADDR_RX_CAL_CTL);
        check(reg_rdata, `RSC_CAL_CTL_RST);
        wr(`RSC_ADDR_PLL_LOCK, 8'hff);
        rd(10'h3ff);
        check(reg_rdata, 8'h00);
        check(state_code, 4'd0);
    endtask : s_reset

    task automatic s_wake();
        int r0;
        int t0;
        wr(`RSC_ADDR_CLK_CTRL, 8'h17);
        for (int i = 0; i < 100 && baseband_pll_locked !== 1'b1; i++)
            @(negedge core_clk);
        rd(`RSC_ADDR_PLL_LOCK);
        check(reg_rdata[7], 1'b1);
        r0 = n_rxcal;
        t0 = n_txcal;
        wr(`RSC_ADDR_CFG1, 8'h0d);
        wait_state(4'd4);
        wr(`RSC_ADDR_CFG1, 8'h2d);
        wait_state(4'd5);
        repeat (8) @(negedge core_clk);
        check(state_code, 4'd5);
        check(n_rxcal - r0, 1);
        check(n_txcal - t0, 0);
        wr(`RSC_ADDR_CFG1, 8'h09);
    endtask : s_wake

    task automatic s_tdd();
        int t0;
        pins(1'b1, 1'b0);
        wait_state(4'd8);
        repeat (2) @(negedge core_clk);
        check(rx_chain_en, 1'b1);
        check(tx_synth_en, 1'b0);
        pins(1'b0, 1'b0);
        wait_state(4'd9);
        wait_state(4'd5);
        t0 = n_txcal;
        pins(1'b0, 1'b1);
        repeat (60) @(negedge core_clk);
        check(n_txcal - t0, 1);
        wr(`RSC_ADDR_CFG1, 8'h08);
        pins(1'b1, 1'b1);
        wait_state(4'd6);
        pins(1'b0, 1'b1);
        wait_state(4'd7);
        wait_state(4'd0);
        pins(1'b1, 1'b1);
        repeat (2) @(negedge core_clk);
        pins(1'b0, 1'b1);
        wait_state(4'd4);
        wait_state(4'd5);
        repeat (10) @(negedge core_clk);
        check(state_code, 4'd5);
    endtask : s_tdd

    task automatic s_indep();
        logic [1:0] k;
        pins(1'b0, 1'b0);
        bus(1'b1, 1'b0, `RSC_ADDR_CFG2, 8'h88);
        rd(`RSC_ADDR_CFG2);
        check(reg_rdata, 8'h88);
        wr(`RSC_ADDR_CFG1, 8'h28);
        wait_state(4'd10);
        check(rx_chain_en, 1'b0);
        check(tx_chain_en, 1'b0);
        for (int i = 1; i < 5; i++)
        begin
            k = 2'(i);
            pins(k[0], k[1]);
            repeat (6) @(negedge core_clk);
            check(rx_chain_en, k[0]);
            check(tx_chain_en, k[1]);
            check(state_code, 4'd10);
        end
        wr(`RSC_ADDR_CFG1, 8'h00);
        wait_state(4'd0);
    endtask : s_indep

    task automatic s_frame();
        @(negedge core_clk);
        tx_data_in = 12'habc;
        @(negedge core_clk);
        check(tx_data_out, 12'h000);
        tx_frame = 1'b1;
        @(negedge core_clk);
        check(tx_data_out, 12'habc);
    endtask : s_frame

    initial
    begin
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        s_reset();
        s_frame();
        s_wake();
        s_tdd();
        s_indep();
        wrap_up();
    end
endmodule : rsc_state_ctrl_tb
`default_nettype wire
